// *** rtl/lpc_capture.sv ***
// lpc_capture: read-only bank of the link parameters received on lane 0,
// plus a control and a status word, behind an APB slave.
// assumes lane 0 delivers its configuration octets already aligned and
// descrambled, one per enabled mclk cycle, with the first octet flagged.
`timescale 1ns/100ps

// Summary of operation
// - each lane 0 parameter has its own read-only field, zero after reset
// - lane identifier reads at bits 4:0 of the first parameter register
// - multiframe clock adjust direction reads at bit 6 of that register
// - phase adjust request reads at bit 5; bit 7 is reserved, reads zero
// - scrambling status at bit 7 of second register, one means enabled
// - lane count at bits 4:0, stored as count minus one
// - octets per frame, eight bits, count minus one; only 1, 2, 4 sent
// - frames per multiframe, five bits, count minus one; only 16 or 32
// - converters per device, eight bits, count minus one; only 1, 2, 4
// - control bits per sample at bits 7:6, bit 5 reserved; sender uses zero
// - converter resolution at bits 4:0 of the control bits register
// - subclass version at bits 7:5 of the following register
module lpc_capture
   import lpc_pkg::*;
(
   input  wire logic                  mclk,
   input  wire logic                  rst_n,
   input  wire logic                  ce,
   input  wire logic                  psel,
   input  wire logic                  penable,
   input  wire logic                  pwrite,
   input  wire logic [LPC_APB_AW-1:0] paddr,
   input  wire logic [31:0]           pwdata,
   input  wire logic [3:0]            pstrb,
   output logic [31:0]                prdata,
   output logic                       pready,
   output logic                       pslverr,
   input  wire logic                  ilas_cfg_valid,
   input  wire logic                  ilas_cfg_first,
   input  wire logic [7:0]            ilas_cfg_octet
);

   typedef struct packed {
      logic [4:0]  rx_lane_identifier;
      logic        rx_phase_adjust_request;
      logic        rx_adjust_direction;
      logic        rx_scrambling_status;
      logic [4:0]  lane_count_m1;
      logic [7:0]  octets_m1;
      logic [4:0]  frames_m1;
      logic [7:0]  conv_m1;
      logic [1:0]  ctrl_bits;
      logic [4:0]  resolution_m1;
      logic [2:0]  rx_subclass_version;
      logic        capture_en;
      logic        check_en;
      logic        captured;
      logic        cksum_err;
      logic [7:0]  capture_cnt;
      logic        pready;
      logic        pslverr;
      logic [31:0] prdata;
   } lpc_state_type;

   lpc_state_type                  st_reg;
   lpc_state_type                  st_next;
   logic                           coll_done;
   logic                           coll_ok;
   logic [LPC_CFG_OCTETS-1:0][7:0] coll_octets;
   logic                           unsupported;
   logic [LPC_IDX_W-1:0]           idx;
   logic                           setup;
   logic                           wr_commit;
   logic                           commit;

   lpc_ilas_collect u_collect (
      .mclk      (mclk),
      .rst_n     (rst_n),
      .ce        (ce),
      .check_en  (st_reg.check_en),
      .cfg_valid (ilas_cfg_valid),
      .cfg_first (ilas_cfg_first),
      .cfg_octet (ilas_cfg_octet),
      .done      (coll_done),
      .sum_ok    (coll_ok),
      .octets    (coll_octets)
   );

   lpc_param_check u_check (
      .octets_m1   (st_reg.octets_m1),
      .frames_m1   (st_reg.frames_m1),
      .conv_m1     (st_reg.conv_m1),
      .ctrl_bits   (st_reg.ctrl_bits),
      .unsupported (unsupported)
   );

   function automatic logic is_mapped(input logic [LPC_IDX_W-1:0] i);
      is_mapped = (i >= LPC_IDX_LANE_ID && i <= LPC_IDX_SUBCLASS) ||
                  (i == LPC_IDX_CTRL) || (i == LPC_IDX_STATUS);
   endfunction : is_mapped

   // reserved bits are left at zero by building each byte from fields
   function automatic logic [31:0] read_word(input logic [LPC_IDX_W-1:0] i,
                                             input lpc_state_type s,
                                             input logic unsup);
      logic [31:0] w;
      w = 32'h0000_0000;
      case (i)
         LPC_IDX_LANE_ID: begin
            w[LPC_LID_MSB:0]  = s.rx_lane_identifier;
            w[LPC_PHADJ_BIT]  = s.rx_phase_adjust_request;
            w[LPC_ADJDIR_BIT] = s.rx_adjust_direction;
         end
         LPC_IDX_SCR_LANES: begin
            w[LPC_SCR_BIT]     = s.rx_scrambling_status;
            w[LPC_LCNT_MSB:0]  = s.lane_count_m1;
         end
         LPC_IDX_OCTETS:   w[7:0] = s.octets_m1;
         LPC_IDX_FRAMES:   w[LPC_K_MSB:0] = s.frames_m1;
         LPC_IDX_CONV:     w[7:0] = s.conv_m1;
         LPC_IDX_CS_RES: begin
            w[LPC_CS_LSB+1:LPC_CS_LSB] = s.ctrl_bits;
            w[LPC_N_MSB:0]             = s.resolution_m1;
         end
         LPC_IDX_SUBCLASS: w[LPC_SUBCLASS_LSB+2:LPC_SUBCLASS_LSB] = s.rx_subclass_version;
         LPC_IDX_CTRL: begin
            w[LPC_CTRL_CAPTURE] = s.capture_en;
            w[LPC_CTRL_CHECK]   = s.check_en;
         end
         LPC_IDX_STATUS: begin
            w[LPC_ST_CAPTURED]                      = s.captured;
            w[LPC_ST_CKSUM_ERR]                     = s.cksum_err;
            w[LPC_ST_UNSUPPORTED]                   = unsup;
            w[LPC_ST_COUNT_LSB+7:LPC_ST_COUNT_LSB]  = s.capture_cnt;
         end
         default: w = 32'h0000_0000;
      endcase
      return w;
   endfunction : read_word

   assign idx       = paddr[LPC_APB_AW-1:2];
   assign setup     = psel && !penable;
   // a write lands only at the access edge, which is also the pready edge
   assign wr_commit = psel && penable && pwrite && st_reg.pready && !st_reg.pslverr;
   assign commit    = coll_done && coll_ok && st_reg.capture_en;

   always_comb begin
      st_next         = st_reg;
      st_next.pready  = 1'b0;
      st_next.pslverr = 1'b0;

      // one wait-free access phase: answer is ready at the first access edge
      if (setup) begin
         st_next.pready  = 1'b1;
         st_next.pslverr = !is_mapped(idx);
         st_next.prdata  = pwrite ? 32'h0000_0000 : read_word(idx, st_reg, unsupported);
      end

      // parameter registers ignore writes; only control and status respond
      if (wr_commit && pstrb[0]) begin
         if (idx == LPC_IDX_CTRL) begin
            st_next.capture_en = pwdata[LPC_CTRL_CAPTURE];
            st_next.check_en   = pwdata[LPC_CTRL_CHECK];
         end
         if (idx == LPC_IDX_STATUS && pwdata[LPC_ST_CKSUM_ERR]) begin
            st_next.cksum_err = 1'b0;
         end
      end

      // set after clear so a fresh checksum error is never lost
      if (coll_done && !coll_ok) begin
         st_next.cksum_err = 1'b1;
      end

      if (commit) begin
         st_next.rx_lane_identifier =
            coll_octets[LPC_OCT_LANE_ID][LPC_LID_MSB:0];
         st_next.rx_phase_adjust_request =
            coll_octets[LPC_OCT_LANE_ID][LPC_PHADJ_BIT];
         st_next.rx_adjust_direction =
            coll_octets[LPC_OCT_LANE_ID][LPC_ADJDIR_BIT];
         st_next.rx_scrambling_status =
            coll_octets[LPC_OCT_SCR_LANES][LPC_SCR_BIT];
         st_next.lane_count_m1 = coll_octets[LPC_OCT_SCR_LANES][LPC_LCNT_MSB:0];
         st_next.octets_m1     = coll_octets[LPC_OCT_OCTETS];
         st_next.frames_m1     = coll_octets[LPC_OCT_FRAMES][LPC_K_MSB:0];
         st_next.conv_m1       = coll_octets[LPC_OCT_CONV];
         st_next.ctrl_bits     =
            coll_octets[LPC_OCT_CS_RES][LPC_CS_LSB+1:LPC_CS_LSB];
         st_next.resolution_m1 = coll_octets[LPC_OCT_CS_RES][LPC_N_MSB:0];
         st_next.rx_subclass_version =
            coll_octets[LPC_OCT_SUBCLASS][LPC_SUBCLASS_LSB+2:LPC_SUBCLASS_LSB];
         st_next.captured    = 1'b1;
         // counter wraps; software compares deltas
         st_next.capture_cnt = st_reg.capture_cnt + 8'h01;
      end
   end

   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         st_reg            <= '0;
         st_reg.capture_en <= LPC_CAPTURE_EN_RST;
         st_reg.check_en   <= LPC_CHECK_EN_RST;
      end else if (ce) begin
         st_reg <= st_next;
      end
   end

   assign prdata  = st_reg.prdata;
   assign pready  = st_reg.pready;
   assign pslverr = st_reg.pslverr;

   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (!rst_n);

   sequence s_read(logic [LPC_IDX_W-1:0] i);
      ce && setup && !pwrite && idx == i;
   endsequence

   sequence s_commit;
      ce && commit;
   endsequence

   chk_reset_clear: assert property (
      $rose(rst_n) |-> (st_reg.rx_lane_identifier == 5'h00 && st_reg.octets_m1 == 8'h00 &&
                        st_reg.conv_m1 == 8'h00 && st_reg.rx_subclass_version == 3'h0 &&
                        !st_reg.rx_scrambling_status && st_reg.frames_m1 == 5'h00))
      else $error("parameter field not zero after reset");

   chk_lane_id_read: assert property (
      s_read(LPC_IDX_LANE_ID) |=>
         pready && prdata[4:0] == $past(st_reg.rx_lane_identifier) && !pslverr)
      else $error("lane identifier read mismatch");

   chk_adjust_dir_read: assert property (
      s_read(LPC_IDX_LANE_ID) |=> prdata[6] == $past(st_reg.rx_adjust_direction))
      else $error("adjust direction read mismatch");

   chk_phase_req_read: assert property (
      s_read(LPC_IDX_LANE_ID) |=>
         prdata[5] == $past(st_reg.rx_phase_adjust_request) && prdata[31:7] == 25'h0)
      else $error("phase request or reserved bit wrong");

   chk_scramble_read: assert property (
      s_read(LPC_IDX_SCR_LANES) |=>
         prdata[7] == $past(st_reg.rx_scrambling_status) && prdata[6:5] == 2'h0)
      else $error("scrambling status read mismatch");

   chk_lane_count_load: assert property (
      s_commit |=> st_reg.lane_count_m1 == $past(coll_octets[LPC_OCT_SCR_LANES][4:0]))
      else $error("lane count not loaded");

   chk_octets_load: assert property (
      s_commit |=> st_reg.octets_m1 == $past(coll_octets[LPC_OCT_OCTETS]))
      else $error("octets per frame not loaded");

   chk_frames_read: assert property (
      s_read(LPC_IDX_FRAMES) |=>
         prdata[4:0] == $past(st_reg.frames_m1) && prdata[7:5] == 3'h0)
      else $error("frames per multiframe read mismatch");

   chk_conv_load: assert property (
      s_commit |=> st_reg.conv_m1 == $past(coll_octets[LPC_OCT_CONV]))
      else $error("converter count not loaded");

   chk_ctrl_bits_read: assert property (
      s_read(LPC_IDX_CS_RES) |=>
         prdata[7:6] == $past(st_reg.ctrl_bits) && prdata[5] == 1'b0)
      else $error("control bits read mismatch");

   chk_resolution_read: assert property (
      s_read(LPC_IDX_CS_RES) |=> prdata[4:0] == $past(st_reg.resolution_m1))
      else $error("resolution read mismatch");

   chk_subclass_read: assert property (
      s_read(LPC_IDX_SUBCLASS) |=>
         prdata[7:5] == $past(st_reg.rx_subclass_version) && prdata[4:0] == 5'h00)
      else $error("subclass version read mismatch");

   chk_fields_hold: assert property (
      !commit |=> $stable(st_reg.rx_lane_identifier) && $stable(st_reg.octets_m1) &&
                  $stable(st_reg.rx_subclass_version) && $stable(st_reg.frames_m1))
      else $error("parameter changed without a new sequence");

   chk_apb_answer: assert property (
      ce && setup |=> pready ##1 (!pready || !ce))
      else $error("apb answer not a single cycle");

endmodule : lpc_capture

// *** rtl/lpc_pkg.sv ***
// lpc_pkg: register indices, field positions, reset values and
// configuration octet layout for the lane 0 link parameter capture block.
// assumes an APB master with 32-bit data; registers sit at byte 4*index.
package lpc_pkg;

   // apb address width; index is paddr[13:2]
   localparam int unsigned LPC_APB_AW         = 14;
   localparam int unsigned LPC_IDX_W          = 12;

   // register indices (byte address is four times the index)
   localparam logic [11:0] LPC_IDX_LANE_ID    = 12'h402;
   localparam logic [11:0] LPC_IDX_SCR_LANES  = 12'h403;
   localparam logic [11:0] LPC_IDX_OCTETS     = 12'h404;
   localparam logic [11:0] LPC_IDX_FRAMES     = 12'h405;
   localparam logic [11:0] LPC_IDX_CONV       = 12'h406;
   localparam logic [11:0] LPC_IDX_CS_RES     = 12'h407;
   localparam logic [11:0] LPC_IDX_SUBCLASS   = 12'h408;
   localparam logic [11:0] LPC_IDX_CTRL       = 12'h410;
   localparam logic [11:0] LPC_IDX_STATUS     = 12'h411;

   // reset values
   localparam logic [7:0]  LPC_FIELD_RESET    = 8'h00;
   localparam logic        LPC_CAPTURE_EN_RST = 1'b1;
   localparam logic        LPC_CHECK_EN_RST   = 1'b1;

   // bit positions inside the parameter registers
   localparam int unsigned LPC_LID_MSB        = 4;
   localparam int unsigned LPC_PHADJ_BIT      = 5;
   localparam int unsigned LPC_ADJDIR_BIT     = 6;
   localparam int unsigned LPC_SCR_BIT        = 7;
   localparam int unsigned LPC_LCNT_MSB       = 4;
   localparam int unsigned LPC_K_MSB          = 4;
   localparam int unsigned LPC_CS_LSB         = 6;
   localparam int unsigned LPC_N_MSB          = 4;
   localparam int unsigned LPC_SUBCLASS_LSB   = 5;

   // control and status bits
   localparam int unsigned LPC_CTRL_CAPTURE   = 0;
   localparam int unsigned LPC_CTRL_CHECK     = 1;
   localparam int unsigned LPC_ST_CAPTURED    = 0;
   localparam int unsigned LPC_ST_CKSUM_ERR   = 1;
   localparam int unsigned LPC_ST_UNSUPPORTED = 2;
   localparam int unsigned LPC_ST_COUNT_LSB   = 8;

   // configuration octet layout of the alignment sequence
   localparam int unsigned LPC_CFG_OCTETS     = 14;
   localparam int unsigned LPC_OCT_LANE_ID    = 2;
   localparam int unsigned LPC_OCT_SCR_LANES  = 3;
   localparam int unsigned LPC_OCT_OCTETS     = 4;
   localparam int unsigned LPC_OCT_FRAMES     = 5;
   localparam int unsigned LPC_OCT_CONV       = 6;
   localparam int unsigned LPC_OCT_CS_RES     = 7;
   localparam int unsigned LPC_OCT_SUBCLASS   = 8;
   localparam logic [3:0]  LPC_OCT_LAST       = 4'hd;

endpackage : lpc_pkg

// *** rtl/lpc_ilas_collect.sv ***
// lpc_ilas_collect: gathers the fourteen configuration octets of one
// alignment sequence and checks the closing checksum octet.
// assumes octets arrive one per enabled cycle, first octet flagged.
`timescale 1ns/100ps
module lpc_ilas_collect
   import lpc_pkg::*;
(
   input  wire logic                                mclk,
   input  wire logic                                rst_n,
   input  wire logic                                ce,
   input  wire logic                                check_en,
   input  wire logic                                cfg_valid,
   input  wire logic                                cfg_first,
   input  wire logic [7:0]                          cfg_octet,
   output logic                                     done,
   output logic                                     sum_ok,
   output logic [LPC_CFG_OCTETS-1:0][7:0]           octets
);

   typedef struct packed {
      logic                              active;
      logic [3:0]                        cnt;
      logic [7:0]                        sum;
      logic                              done;
      logic                              sum_ok;
      logic [LPC_CFG_OCTETS-1:0][7:0]    mem;
   } lpc_coll_type;

   lpc_coll_type st_reg;
   lpc_coll_type st_next;

   always_comb begin
      st_next      = st_reg;
      st_next.done = 1'b0;
      if (cfg_valid && cfg_first) begin
         st_next.active = 1'b1;
         st_next.cnt    = 4'h1;
         st_next.sum    = cfg_octet;
         st_next.mem[0] = cfg_octet;
      end else if (cfg_valid && st_reg.active) begin
         st_next.mem[st_reg.cnt] = cfg_octet;
         st_next.cnt             = st_reg.cnt + 4'h1;
         if (st_reg.cnt == LPC_OCT_LAST) begin
            // checksum octet closes the sequence
            st_next.active = 1'b0;
            st_next.done   = 1'b1;
            st_next.sum_ok = (st_reg.sum == cfg_octet) || !check_en;
         end else begin
            st_next.sum = st_reg.sum + cfg_octet;
         end
      end
   end

   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         st_reg <= '0;
      end else if (ce) begin
         st_reg <= st_next;
      end
   end

   assign done   = st_reg.done;
   assign sum_ok = st_reg.sum_ok;
   assign octets = st_reg.mem;

endmodule : lpc_ilas_collect

// *** rtl/lpc_param_check.sv ***
// lpc_param_check: flags captured parameters that this receiver cannot use.
// assumes fields are given in count-minus-one form as stored.
`timescale 1ns/100ps
module lpc_param_check
   import lpc_pkg::*;
(
   input  wire logic [7:0] octets_m1,
   input  wire logic [4:0] frames_m1,
   input  wire logic [7:0] conv_m1,
   input  wire logic [1:0] ctrl_bits,
   output logic            unsupported
);

   // accepted counts 1, 2 and 4
   function automatic logic one_two_four(input logic [7:0] m1);
      one_two_four = (m1 == 8'h00) || (m1 == 8'h01) || (m1 == 8'h03);
   endfunction : one_two_four

   always_comb begin
      unsupported = 1'b0;
      if (!one_two_four(octets_m1)) unsupported = 1'b1;
      if (frames_m1 != 5'h0f && frames_m1 != 5'h1f) unsupported = 1'b1;
      if (!one_two_four(conv_m1)) unsupported = 1'b1;
      if (ctrl_bits != 2'h0) unsupported = 1'b1;
   end

endmodule : lpc_param_check

// *** dv/lpc_link_model.sv ***
// lpc_link_model: lane 0 transmitter, sends one alignment sequence per go.
// assumes tb pulses go for one cycle while busy is low; params are octets 2..8.
`timescale 1ns/100ps
module lpc_link_model
   import lpc_pkg::*;
(
   input  wire logic            mclk,
   input  wire logic            rst_n,
   input  wire logic            go,
   input  wire logic            slow,
   input  wire logic            corrupt,
   input  wire logic [6:0][7:0] params,
   output logic                 ilas_cfg_valid,
   output logic                 ilas_cfg_first,
   output logic [7:0]           ilas_cfg_octet,
   output logic                 busy
);
   logic [3:0] idx;
   logic [7:0] sum;
   logic [7:0] cur;
   logic       stall;

   always_comb begin
      if (idx == LPC_OCT_LAST) begin
         cur = sum + {7'h00, corrupt};
      end else if (idx >= 4'h2 && idx <= 4'h8) begin
         cur = params[idx - 4'h2];
      end else begin
         cur = {4'ha, idx};
      end
   end

   // idle octet lines toggle so stale data is never mistaken for valid
   always @(posedge mclk) begin
      if (!rst_n || !busy) begin
         busy           <= rst_n && go;
         idx            <= 4'h0;
         sum            <= 8'h00;
         stall          <= 1'b0;
         ilas_cfg_valid <= 1'b0;
         ilas_cfg_first <= 1'b0;
         ilas_cfg_octet <= ~ilas_cfg_octet;
      end else if (slow && !stall) begin
         stall          <= 1'b1;
         ilas_cfg_valid <= 1'b0;
         ilas_cfg_first <= 1'b0;
         ilas_cfg_octet <= ~ilas_cfg_octet;
      end else begin
         stall          <= 1'b0;
         ilas_cfg_valid <= 1'b1;
         ilas_cfg_first <= (idx == 4'h0);
         ilas_cfg_octet <= cur;
         sum            <= sum + cur;
         idx            <= idx + 4'h1;
         busy           <= (idx != LPC_OCT_LAST);
      end
   end
endmodule : lpc_link_model

// *** dv/tb.sv ***
// tb: apb reads of the lane 0 parameter bank after link sequences.
// assumes lpc_capture answers in one access cycle, ce held high.
`timescale 1ns/100ps
module tb;
   import lpc_pkg::*;
   logic            mclk = 1'b0;
   logic            rst_n, ce, psel, penable, pwrite;
   logic [13:0]     paddr;
   logic [31:0]     pwdata, prdata, rd;
   logic [3:0]      pstrb;
   logic            pready, pslverr, err;
   logic            cv, cf, tx_go, tx_slow, tx_bad, tx_busy;
   logic [7:0]      co;
   logic [6:0][7:0] tx_p;
   int              num_errors, check_count, cyc;
   // octets 2..8 sent, and what each register must read back
   logic [6:0][7:0] snd_a = {8'h3f, 8'h2f, 8'h03, 8'hef, 8'h01, 8'he1, 8'he3};
   logic [6:0][7:0] exp_a = {8'h20, 8'h0f, 8'h03, 8'h0f, 8'h01, 8'h81, 8'h63};
   logic [6:0][7:0] snd_b = {8'h5a, 8'h0d, 8'h00, 8'h1f, 8'h03, 8'h1e, 8'h9c};
   logic [6:0][7:0] exp_b = {8'h40, 8'h0d, 8'h00, 8'h1f, 8'h03, 8'h1e, 8'h1c};

   always #2.5 mclk = ~mclk;

   lpc_capture lpc_capture_inst (.mclk(mclk), .rst_n(rst_n), .ce(ce), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .ilas_cfg_valid(cv),
      .ilas_cfg_first(cf), .ilas_cfg_octet(co));
   lpc_link_model lpc_link_model_inst (.mclk(mclk), .rst_n(rst_n), .go(tx_go),
      .slow(tx_slow), .corrupt(tx_bad), .params(tx_p), .ilas_cfg_valid(cv),
      .ilas_cfg_first(cf), .ilas_cfg_octet(co), .busy(tx_busy));

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         num_errors++;
         $display("[ERR] t=%0t seen=%h expected=%h", $time, seen, exp);
      end
   endtask : chk

   task automatic apb(input logic wr, input logic [11:0] idx, input logic [31:0] wd);
      int n;
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= wr;
      paddr   <= {idx, 2'b00};
      pwdata  <= wd;
      pstrb   <= 4'hf;
      @(posedge mclk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge mclk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      rd  = prdata;
      err = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
      if (n >= 50) num_errors++;
      @(posedge mclk);
   endtask : apb

   task automatic rd_chk(input logic [11:0] idx, input logic [31:0] exp);
      apb(1'b0, idx, 32'h0);
      chk(rd, exp);
      chk({31'h0, err}, 32'h0);
   endtask : rd_chk

   task automatic bank_chk(input logic [6:0][7:0] e);
      for (int i = 0; i < 7; i++) begin
         rd_chk(LPC_IDX_LANE_ID + 12'(i), {24'h0, e[i]});
      end
   endtask : bank_chk

   task automatic send(input logic [6:0][7:0] p, input logic s, input logic bad);
      int n;
      tx_p    <= p;
      tx_slow <= s;
      tx_bad  <= bad;
      tx_go   <= 1'b1;
      @(posedge mclk);
      tx_go <= 1'b0;
      n = 0;
      do begin
         @(posedge mclk);
         n++;
      end while ((tx_busy !== 1'b0 || n < 2) && n < 100);
      if (n >= 100) num_errors++;
      // fields land two edges after the checksum octet
      repeat (3) @(posedge mclk);
   endtask : send

   task automatic wrap_up;
      $display("checks=%0d errors=%0d", check_count, num_errors);
      if (num_errors == 0 && check_count > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask : wrap_up

   always @(posedge mclk) begin
      cyc++;
      if (cyc == 20000) begin
         num_errors++;
         wrap_up();
      end
   end

   initial begin
      {psel, penable, pwrite, tx_go, tx_slow, tx_bad} = '0;
      {paddr, pwdata, pstrb, tx_p} = '0;
      rst_n = 1'b0;
      ce    = 1'b1;
      repeat (10) @(posedge mclk);
      rst_n <= 1'b1;
      @(posedge mclk);
      bank_chk('0);
      send(snd_a, 1'b0, 1'b0);
      bank_chk(exp_a);
      rd_chk(LPC_IDX_STATUS, 32'h0101);
      send(snd_b, 1'b1, 1'b0);
      bank_chk(exp_b);
      send(snd_a, 1'b0, 1'b1);
      bank_chk(exp_b);
      rd_chk(LPC_IDX_STATUS, 32'h0203);
      apb(1'b1, LPC_IDX_STATUS, 32'h2);
      rd_chk(LPC_IDX_STATUS, 32'h0201);
      apb(1'b1, LPC_IDX_OCTETS, 32'hff);
      rd_chk(LPC_IDX_OCTETS, 32'h03);
      apb(1'b0, 12'h409, 32'h0);
      chk({31'h0, err}, 32'h1);
      chk(rd, 32'h0);
      wrap_up();
   end
endmodule : tb
